//--- src/tsens_pkg.sv
// Purpose: shared constants for the temperature sensor register port
// Assumes: 125 MHz system clock
// Notes: register map, reset values, field positions and counts
// Functional notes
// [RULE1] Answer only the fixed 7-bit own address
// [RULE2] Pointer picks temperature, config or limit registers
// [RULE3] Master sends pointer right after write address
// [RULE4] Pointer never auto-increments during a transfer
// [RULE5] Lone data byte lands in bits 15:8
// [RULE6] Extra written bytes go to same register
// [RULE7] Extra read bytes come from same register
// [RULE8] Read: address, pointer, restart, read address
// [RULE9] Temperature read-only; other three read-write
// [RULE10] Result two's complement in 15:3, high first
// [RULE11] LSB 1 C at 8 bits, 0.0625 C at 12
// [RULE12] Extended format: bit 14 weighs 128 C
// [RULE13] Limits share the result number format
// [RULE14] Hysteresis above overtemp acts as overtemp
// [RULE15] One-shot in shutdown converts, then clears bit
// [RULE16] One-shot outside shutdown does nothing
// [RULE17] Config bit 4 high disables bus timeout
// [RULE18] Clock low past 30 ms resets interface
// [RULE19] Power-on values 0000, 0040, 4B00, 5000
// [RULE20] Master acks high byte, nacks last, stops
// [RULE21] With checking on, send CRC-8 after low byte
// [RULE22] Config bit 8 enters shutdown
// [RULE23] Config bits 6:5 select 8/9/10/12 bits
// [RULE24] Ignore foreign addresses until next start
package tsens_pkg;
	// Pointer values
	localparam logic [1:0]  PTR_TEMP      = 2'h0;
	localparam logic [1:0]  PTR_CFG       = 2'h1;
	localparam logic [1:0]  PTR_HYST      = 2'h2;
	localparam logic [1:0]  PTR_OS        = 2'h3;
	// Power-on values
	localparam logic [15:0] TEMP_RESET    = 16'h0000;
	localparam logic [15:0] CFG_RESET     = 16'h0040;
	localparam logic [15:0] HYST_RESET    = 16'h4B00;
	localparam logic [15:0] OS_RESET      = 16'h5000;
	// Configuration field positions
	localparam int          CFG_ONESHOT   = 0;
	localparam int          CFG_PEC       = 3;
	localparam int          CFG_TOUT_DIS  = 4;
	localparam int          CFG_RES_LO    = 5;
	localparam int          CFG_FMT       = 7;
	localparam int          CFG_SHDN      = 8;
	// Resolution codes and lowest kept bit in normal format
	localparam logic [1:0]  RES_8         = 2'h0;
	localparam logic [1:0]  RES_9         = 2'h1;
	localparam logic [1:0]  RES_10        = 2'h2;
	localparam logic [3:0]  LSB_POS_8     = 4'h8;
	localparam logic [3:0]  LSB_POS_9     = 4'h7;
	localparam logic [3:0]  LSB_POS_10    = 4'h6;
	localparam logic [3:0]  LSB_POS_12    = 4'h4;
	// Bit counts within a byte slot, check polynomial and own address
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [3:0]  ACK_SLOT      = 4'h9;
	localparam logic [7:0]  CRC_POLY      = 8'h07;
	localparam logic [6:0]  OWN_ADDR      = 7'h48;
	// Bus timeout
	localparam int          TIMEOUT_MS    = 30;
	localparam int          CLK_KHZ       = 125000;
	localparam int          TIMEOUT_CYC   = TIMEOUT_MS * CLK_KHZ;
	// Link states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_RX   = 5'h04,
		ST_TX   = 5'h08,
		ST_SKIP = 5'h10
	} link_state_e;
endpackage : tsens_pkg

//--- src/bus_events_if.sv
// Purpose: filtered serial bus levels and events
// Assumes: all signals on clk, events as one-cycle pulses
// Notes: front end drives, register port consumes
`timescale 1ns/1ns
interface bus_events_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic timeout;
	modport front (output scl, sda, scl_rise, scl_fall, start, stop, timeout);
	modport core  (input  scl, sda, scl_rise, scl_fall, start, stop, timeout);
endinterface : bus_events_if

//--- src/pin_front.sv
// Purpose: pin synchronisers, start/stop detect, bus timeout
// Assumes: scl_i and sda_i asynchronous to clk
// Notes: a change counts once the second and third stages agree
`timescale 1ns/1ns
module pin_front #(
	parameter int TIMEOUT_CYCLES = tsens_pkg::TIMEOUT_CYC
) (
	input  wire logic  clk,
	input  wire logic  sys_rst,
	input  wire logic  ce,
	input  wire logic  scl_i,
	input  wire logic  sda_i,
	input  wire logic  tout_en,
	bus_events_if.front ev
);
	localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [CW-1:0] TOUT_LAST = CW'(TIMEOUT_CYCLES - 1);
	localparam logic [CW-1:0] TOUT_HOLD = CW'(TIMEOUT_CYCLES);

	logic [2:0]    scl_sync;
	logic [2:0]    sda_sync;
	logic [CW-1:0] tout_cnt;
	logic          scl_ok;
	logic          sda_ok;

	// Three-stage synchronisers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else if (ce) begin
			scl_sync <= {scl_sync[1:0], scl_i};
			sda_sync <= {sda_sync[1:0], sda_i};
		end
	end

	assign scl_ok = (scl_sync[1] == scl_sync[2]);
	assign sda_ok = (sda_sync[1] == sda_sync[2]);

	// Accepted levels and edge events
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ev.scl      <= 1'b1;
			ev.sda      <= 1'b1;
			ev.scl_rise <= 1'b0;
			ev.scl_fall <= 1'b0;
			ev.start    <= 1'b0;
			ev.stop     <= 1'b0;
		end else if (ce) begin
			if (scl_ok)
				ev.scl <= scl_sync[2];
			if (sda_ok)
				ev.sda <= sda_sync[2];
			ev.scl_rise <= scl_ok && scl_sync[2] && !ev.scl;
			ev.scl_fall <= scl_ok && !scl_sync[2] && ev.scl;
			ev.start    <= sda_ok && !sda_sync[2] && ev.sda && ev.scl;
			ev.stop     <= sda_ok && sda_sync[2] && !ev.sda && ev.scl;
		end
	end

	// Clock-low watchdog, fires once per low period
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tout_cnt   <= '0;
			ev.timeout <= 1'b0;
		end else if (ce) begin
			ev.timeout <= 1'b0;
			if (ev.scl || !tout_en) begin // [RULE17]
				tout_cnt <= '0;
			end else if (tout_cnt == TOUT_LAST) begin
				tout_cnt   <= TOUT_HOLD;
				ev.timeout <= 1'b1; // [RULE18]
			end else if (tout_cnt != TOUT_HOLD) begin
				tout_cnt <= tout_cnt + 1'b1;
			end
		end
	end

	a_tout_disabled: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
		ce && !tout_en |=> !ev.timeout && tout_cnt == '0)
		else $error("timeout fired while disabled");
endmodule : pin_front

//--- src/tsens_regport.sv
// Purpose: serial register port of a temperature sensor
// Assumes: conversion engine supplies raw samples in 1/16 C
// Notes: open-drain data pin, clock input sampled by clk
`timescale 1ns/1ns
module tsens_regport #(
	parameter logic [6:0] DEV_ADDR       = tsens_pkg::OWN_ADDR,
	parameter int         TIMEOUT_CYCLES = tsens_pkg::TIMEOUT_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        conv_done,
	input  wire logic [15:0] conv_raw,
	output logic             conv_start,
	output logic             conv_shutdown,
	output logic [1:0]       conv_res,
	output logic [15:0]      hyst_eff,
	output logic [15:0]      overtemp_out
);
	bus_events_if ev ();

	tsens_pkg::link_state_e state;
	logic [3:0]  bit_cnt;
	logic [7:0]  shift;
	logic [7:0]  tx_byte;
	logic [15:0] tx_word;
	logic [1:0]  tx_phase;
	logic        master_ack;
	logic        ptr_next;
	logic        lo_next;
	logic [1:0]  pointer;
	logic [7:0]  crc;
	logic        wr_hi_stb;
	logic        wr_lo_stb;
	logic [7:0]  wr_data;
	logic [1:0]  wr_ptr;
	logic [15:0] temp_reg;
	logic [15:0] cfg;
	logic [15:0] hyst;
	logic [15:0] os;
	logic        byte_end;
	logic        ack_end;
	logic        addr_hit;
	logic        oneshot_set;

	pin_front #(
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_front (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.tout_en (!cfg[tsens_pkg::CFG_TOUT_DIS]),
		.ev      (ev)
	);

	// CRC-8 of one byte, MSB first
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[7] ^ d[i])
				r = {r[6:0], 1'b0} ^ tsens_pkg::CRC_POLY;
			else
				r = {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc8

	// Place a raw sample and clear bits below the resolution
	function automatic logic [15:0] fmt_temp(input logic [15:0] raw, input logic ext,
		input logic [1:0] res);
		logic [15:0] v;
		logic [3:0]  p;
		v = ext ? {raw[12:0], 3'h0} : {raw[11:0], 4'h0}; // [RULE10] [RULE12]
		case (res) // [RULE23]
			tsens_pkg::RES_8:  p = tsens_pkg::LSB_POS_8; // [RULE11]
			tsens_pkg::RES_9:  p = tsens_pkg::LSB_POS_9;
			tsens_pkg::RES_10: p = tsens_pkg::LSB_POS_10;
			default:           p = tsens_pkg::LSB_POS_12;
		endcase
		p = p - {3'h0, ext};
		return v & (16'hFFFF << p);
	endfunction : fmt_temp

	// Register selected by a pointer value
	function automatic logic [15:0] reg_sel(input logic [1:0] ptr);
		case (ptr) // [RULE2]
			tsens_pkg::PTR_TEMP: reg_sel = temp_reg;
			tsens_pkg::PTR_CFG:  reg_sel = cfg;
			tsens_pkg::PTR_HYST: reg_sel = hyst;
			default:             reg_sel = os;
		endcase
	endfunction : reg_sel

	// Byte slot boundaries, only when no bus event overrides
	assign byte_end = ce && !ev.stop && !ev.timeout && !ev.start && ev.scl_fall &&
		bit_cnt == tsens_pkg::BYTE_BITS;
	assign ack_end  = ce && !ev.stop && !ev.timeout && !ev.start && ev.scl_fall &&
		bit_cnt == tsens_pkg::ACK_SLOT;
	assign addr_hit = (shift[7:1] == DEV_ADDR); // [RULE1]

	// Link state, bit counter and data pin drive
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state      <= tsens_pkg::ST_IDLE;
			bit_cnt    <= 4'h0;
			shift      <= 8'h00;
			tx_byte    <= 8'h00;
			tx_word    <= 16'h0000;
			tx_phase   <= 2'h0;
			master_ack <= 1'b0;
			ptr_next   <= 1'b0;
			lo_next    <= 1'b0;
			pointer    <= tsens_pkg::PTR_TEMP;
			sda_oe     <= 1'b0;
			wr_hi_stb  <= 1'b0;
			wr_lo_stb  <= 1'b0;
			wr_data    <= 8'h00;
			wr_ptr     <= tsens_pkg::PTR_TEMP;
		end else if (ce) begin
			wr_hi_stb <= 1'b0;
			wr_lo_stb <= 1'b0;
			if (ev.timeout || ev.stop) begin // [RULE18]
				state   <= tsens_pkg::ST_IDLE;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (ev.start) begin // [RULE24]
				state   <= tsens_pkg::ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else begin
				case (state)
					tsens_pkg::ST_ADDR, tsens_pkg::ST_RX, tsens_pkg::ST_TX: begin
						if (ev.scl_rise) begin
							if (bit_cnt < tsens_pkg::BYTE_BITS)
								shift <= {shift[6:0], ev.sda};
							else
								master_ack <= !ev.sda;
							bit_cnt <= bit_cnt + 4'h1;
						end
						if (byte_end) begin
							if (state == tsens_pkg::ST_ADDR) begin
								if (!addr_hit) begin
									state  <= tsens_pkg::ST_SKIP; // [RULE24]
									sda_oe <= 1'b0;
								end else if (shift[0]) begin
									state    <= tsens_pkg::ST_TX; // [RULE8]
									sda_oe   <= 1'b1;
									tx_word  <= reg_sel(pointer);
									tx_phase <= 2'h0;
								end else begin
									state    <= tsens_pkg::ST_RX;
									sda_oe   <= 1'b1;
									ptr_next <= 1'b1; // [RULE3]
									lo_next  <= 1'b0;
								end
							end else if (state == tsens_pkg::ST_RX) begin
								sda_oe <= 1'b1;
								if (ptr_next) begin
									pointer  <= shift[1:0]; // [RULE2]
									ptr_next <= 1'b0;
								end else begin
									wr_hi_stb <= !lo_next; // [RULE5]
									wr_lo_stb <= lo_next;
									lo_next   <= !lo_next; // [RULE6]
									wr_data   <= shift;
									wr_ptr    <= pointer; // [RULE4]
								end
							end else begin
								sda_oe <= 1'b0;
							end
						end else if (ack_end) begin
							bit_cnt <= 4'h0;
							if (state == tsens_pkg::ST_TX && master_ack) begin
								case (tx_phase)
									2'h0: begin
										tx_byte  <= tx_word[15:8]; // [RULE10]
										sda_oe   <= !tx_word[15];
										tx_phase <= 2'h1;
									end
									2'h1: begin
										tx_byte  <= tx_word[7:0];
										sda_oe   <= !tx_word[7];
										tx_phase <= cfg[tsens_pkg::CFG_PEC] ? 2'h2 : 2'h0; // [RULE7]
									end
									default: begin
										tx_byte  <= crc; // [RULE21]
										sda_oe   <= !crc[7];
										tx_phase <= 2'h0;
									end
								endcase
							end else if (state == tsens_pkg::ST_TX) begin
								state  <= tsens_pkg::ST_SKIP; // [RULE20]
								sda_oe <= 1'b0;
							end else begin
								sda_oe <= 1'b0;
							end
						end else if (ev.scl_fall && state == tsens_pkg::ST_TX &&
							bit_cnt < tsens_pkg::BYTE_BITS) begin
							tx_byte <= {tx_byte[6:0], 1'b0};
							sda_oe  <= !tx_byte[6];
						end
					end
					tsens_pkg::ST_IDLE, tsens_pkg::ST_SKIP: begin
						sda_oe <= 1'b0;
					end
					default: begin
						state  <= tsens_pkg::ST_IDLE;
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Check byte over every byte of the message
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			crc <= 8'h00;
		end else if (ce) begin
			if (ev.start && (state == tsens_pkg::ST_IDLE || state == tsens_pkg::ST_SKIP))
				crc <= 8'h00;
			else if (byte_end && state != tsens_pkg::ST_SKIP)
				crc <= crc8(crc, shift); // [RULE21]
		end
	end

	// Limit registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hyst <= tsens_pkg::HYST_RESET; // [RULE19]
			os   <= tsens_pkg::OS_RESET;
		end else if (ce) begin
			if (wr_hi_stb && wr_ptr == tsens_pkg::PTR_HYST)
				hyst[15:8] <= wr_data; // [RULE5]
			if (wr_lo_stb && wr_ptr == tsens_pkg::PTR_HYST)
				hyst[7:0] <= wr_data;
			if (wr_hi_stb && wr_ptr == tsens_pkg::PTR_OS)
				os[15:8] <= wr_data;
			if (wr_lo_stb && wr_ptr == tsens_pkg::PTR_OS)
				os[7:0] <= wr_data;
		end
	end

	// Temperature result, bus writes never reach it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			temp_reg <= tsens_pkg::TEMP_RESET; // [RULE19]
		else if (ce && conv_done) // [RULE9]
			temp_reg <= fmt_temp(conv_raw, cfg[tsens_pkg::CFG_FMT],
				cfg[tsens_pkg::CFG_RES_LO+1:tsens_pkg::CFG_RES_LO]);
	end

	assign oneshot_set = wr_lo_stb && wr_ptr == tsens_pkg::PTR_CFG && wr_data[0] &&
		cfg[tsens_pkg::CFG_SHDN];

	// Configuration, one-shot bit set wins over its clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg        <= tsens_pkg::CFG_RESET; // [RULE19]
			conv_start <= 1'b0;
		end else if (ce) begin
			conv_start <= 1'b0;
			if (wr_hi_stb && wr_ptr == tsens_pkg::PTR_CFG) begin
				cfg[14:8] <= wr_data[6:0]; // [RULE22]
				conv_start <= cfg[tsens_pkg::CFG_SHDN] && !wr_data[0];
			end
			if (wr_lo_stb && wr_ptr == tsens_pkg::PTR_CFG)
				cfg[7:1] <= wr_data[7:1]; // [RULE17] [RULE23]
			if (conv_done)
				cfg[tsens_pkg::CFG_ONESHOT] <= 1'b0; // [RULE15]
			if (oneshot_set) begin // [RULE16]
				cfg[tsens_pkg::CFG_ONESHOT] <= 1'b1;
				conv_start <= !cfg[tsens_pkg::CFG_ONESHOT];
			end
		end
	end

	// Effective limits, compared as signed results
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hyst_eff     <= tsens_pkg::HYST_RESET;
			overtemp_out <= tsens_pkg::OS_RESET;
		end else if (ce) begin
			hyst_eff     <= ($signed(hyst) > $signed(os)) ? os : hyst; // [RULE13] [RULE14]
			overtemp_out <= os;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			sda_o <= 1'b0;
		else if (ce)
			sda_o <= 1'b0;
	end

	assign conv_shutdown = cfg[tsens_pkg::CFG_SHDN]; // [RULE22]
	assign conv_res      = cfg[tsens_pkg::CFG_RES_LO+1:tsens_pkg::CFG_RES_LO];

	a_foreign_nack: assert property (@(posedge clk) disable iff (sys_rst) // [RULE24]
		byte_end && state == tsens_pkg::ST_ADDR && !addr_hit
		|=> state == tsens_pkg::ST_SKIP && !sda_oe)
		else $error("foreign address not ignored");
	a_own_ack: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		byte_end && state == tsens_pkg::ST_ADDR && addr_hit |=> sda_oe)
		else $error("own address not acknowledged");
	a_temp_ro: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
		(wr_hi_stb || wr_lo_stb) && wr_ptr == tsens_pkg::PTR_TEMP && !conv_done
		|=> $stable(temp_reg))
		else $error("temperature register written by bus");
	a_hi_byte: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		ce && wr_hi_stb && wr_ptr == tsens_pkg::PTR_OS
		|=> os[15:8] == $past(wr_data) && $stable(os[7:0]))
		else $error("single byte not stored in upper half");
	a_ptr_fixed: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		byte_end && state == tsens_pkg::ST_RX && !ptr_next |=> $stable(pointer))
		else $error("pointer moved during data transfer");
	a_hyst_clamp: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
		ce |=> $signed(hyst_eff) <= $signed($past(os)))
		else $error("effective hysteresis above overtemp limit");
	a_oneshot_ign: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
		ce && wr_lo_stb && wr_ptr == tsens_pkg::PTR_CFG && !cfg[tsens_pkg::CFG_SHDN] &&
		!cfg[tsens_pkg::CFG_ONESHOT] |=> !cfg[tsens_pkg::CFG_ONESHOT] && !conv_start)
		else $error("one-shot acted outside shutdown");
	a_oneshot_done: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
		ce && conv_done && !oneshot_set |=> !cfg[tsens_pkg::CFG_ONESHOT])
		else $error("one-shot bit not cleared at completion");
	a_tout_idle: assert property (@(posedge clk) disable iff (sys_rst) // [RULE18]
		ce && ev.timeout |=> state == tsens_pkg::ST_IDLE && !sda_oe)
		else $error("timeout did not reset interface");
	a_temp_low_zero: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
		ce && conv_done |=> temp_reg[2:0] == 3'h0)
		else $error("result low bits not zero");
endmodule : tsens_regport

//--- bench/i2c_master_model.sv
// Purpose: serial bus master that drives the sensor register port
// Assumes: bus clock half period of 10 clk, i.e. a 160 ns bus period
// Notes: data line is open drain; a released line reads as the pull-up
`timescale 1ns/1ns
module i2c_master_model (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// Idle bus: clock high and data released
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end
	// Wait whole system clocks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// One bit slot: data changes mid-low, sampled mid-high
	task automatic bit_slot(input logic b, output logic s);
		scl     <= 1'b0;
		tick(5);
		sda_low <= ~b;
		tick(5);
		scl     <= 1'b1;
		tick(5);
		s = sda;
		tick(5);
	endtask : bit_slot
	// Start from idle: data falls while clock high
	task automatic start_cond();
		sda_low <= 1'b1;
		tick(10);
	endtask : start_cond
	// Repeated start after an acknowledge slot
	task automatic restart();
		scl     <= 1'b0;
		tick(5);
		sda_low <= 1'b0;
		tick(5);
		scl     <= 1'b1;
		tick(10);
		sda_low <= 1'b1;
		tick(10);
	endtask : restart
	// Stop: data rises while clock high, then the clock stands still
	task automatic stop_cond();
		scl     <= 1'b0;
		tick(5);
		sda_low <= 1'b1;
		tick(5);
		scl     <= 1'b1;
		tick(10);
		sda_low <= 1'b0;
		tick(10);
	endtask : stop_cond
	// Eight bits out, then release for the device acknowledge
	task automatic byte_out(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_slot(b[i], s);
		bit_slot(1'b1, ack);
	endtask : byte_out
	// Eight bits in, then acknowledge or not-acknowledge
	task automatic byte_in(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_slot(1'b1, b[i]);
		bit_slot(last, s);
	endtask : byte_in
	// Clock held low to stretch the current slot
	task automatic hold_low(input int n);
		scl <= 1'b0;
		tick(n);
	endtask : hold_low
	// Write: address, pointer straight after, then n data bytes
	task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr,
		input logic [31:0] d, input int n, output logic ack);
		logic a;
		start_cond();
		byte_out({addr, 1'b0}, ack);
		byte_out(ptr, a);
		for (int i = 0; i < n; i++)
			byte_out(d[31-8*i -: 8], a);
		stop_cond();
	endtask : write_reg
	// Read: pointer, repeated start, read address, n bytes, last one refused
	task automatic read_reg(input logic [7:0] ptr, input int n, output logic [31:0] d);
		logic       a;
		logic [7:0] b;
		d = 32'h0000_0000;
		start_cond();
		byte_out({tsens_pkg::OWN_ADDR, 1'b0}, a);
		byte_out(ptr, a);
		restart();
		byte_out({tsens_pkg::OWN_ADDR, 1'b1}, a);
		for (int i = 0; i < n; i++) begin
			byte_in(i == n - 1, b);
			d[31-8*i -: 8] = b;
		end
		stop_cond();
	endtask : read_reg
endmodule : i2c_master_model

//--- bench/test_tsens_regport.sv
// Purpose: self-checking bench for the sensor register port
// Assumes: short bus timeout of 200 clk, conversion engine modelled here
// Notes: data wire resolves to low when any party pulls it
`timescale 1ns/1ns
module test_tsens_regport;
	localparam int TOUT = 200;
	logic        clk;
	logic        sys_rst;
	logic        ce;
	logic        conv_done;
	logic [15:0] conv_raw;
	logic        sda_o;
	logic        sda_oe;
	logic        conv_start;
	logic        conv_shutdown;
	logic [1:0]  conv_res;
	logic [15:0] hyst_eff;
	logic [15:0] overtemp_out;
	logic        scl;
	logic        sda_low;
	wire logic   sda;
	int          bad_count = 0;
	int          n_checks  = 0;
	int          starts    = 0;
	// Open-drain wire with pull-up
	assign sda = (sda_oe === 1'b1 || sda_low === 1'b1) ? 1'b0 : 1'b1;
	tsens_regport #(.TIMEOUT_CYCLES(TOUT)) tsens_regport_i (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .conv_done(conv_done), .conv_raw(conv_raw),
		.conv_start(conv_start), .conv_shutdown(conv_shutdown), .conv_res(conv_res),
		.hyst_eff(hyst_eff), .overtemp_out(overtemp_out)
	);
	i2c_master_model i2c_master_model_i (
		.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low)
	);
	// Clock and conversion start counter
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;
	// Counts and verdict
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Short hands for own-address traffic
	task automatic wr(input logic [7:0] p, input logic [31:0] d, input int n);
		logic a;
		i2c_master_model_i.write_reg(tsens_pkg::OWN_ADDR, p, d, n, a);
		chk({15'h0000, a}, 16'h0000);
	endtask : wr
	task automatic rd(input logic [7:0] p, input int n, output logic [31:0] d);
		i2c_master_model_i.read_reg(p, n, d);
	endtask : rd
	// Power-on register values and limit outputs
	task automatic t_reset();
		logic [31:0] d;
		logic [15:0] por [4] = '{tsens_pkg::TEMP_RESET, tsens_pkg::CFG_RESET,
			tsens_pkg::HYST_RESET, tsens_pkg::OS_RESET};
		chk(hyst_eff, 16'h4B00);
		chk(overtemp_out, 16'h5000);
		for (int i = 0; i < 4; i++) begin
			rd(8'(i), 2, d);
			chk(d[31:16], por[i]);
		end
	endtask : t_reset
	// Foreign address: refused and its data ignored
	task automatic t_foreign();
		logic        a;
		logic [31:0] d;
		i2c_master_model_i.write_reg(7'h49, 8'h02, 32'h0102_0000, 2, a);
		chk({15'h0000, a}, 16'h0001);
		rd(8'h02, 2, d);
		chk(d[31:16], 16'h4B00);
	endtask : t_foreign
	// Limits: excess and lone bytes, clamp of hysteresis
	task automatic t_limits();
		logic [31:0] d;
		wr(8'h02, 32'h1122_2800, 3);
		rd(8'h02, 3, d);
		chk(d[31:16], 16'h2822);
		chk({8'h00, d[15:8]}, 16'h0028);
		wr(8'h03, 32'h6000_0000, 1);
		rd(8'h03, 2, d);
		chk(d[31:16], 16'h6000);
		chk(overtemp_out, 16'h6000);
		wr(8'h02, 32'h7000_0000, 2);
		chk(hyst_eff, 16'h6000);
		rd(8'h02, 2, d);
		chk(d[31:16], 16'h7000);
	endtask : t_limits
	// Result register refuses writes
	task automatic t_temp_ro();
		logic [31:0] d;
		wr(8'h00, 32'hABCD_0000, 2);
		rd(8'h00, 2, d);
		chk(d[31:16], 16'h0000);
	endtask : t_temp_ro
	// One-shot outside shutdown starts nothing
	task automatic t_oneshot_idle();
		int s0;
		s0 = starts;
		wr(8'h01, 32'h0041_0000, 2);
		i2c_master_model_i.tick(20);
		chk(16'(starts), 16'(s0));
	endtask : t_oneshot_idle
	// Check byte appended to a read when checking is on
	task automatic t_pec();
		logic [31:0] d;
		wr(8'h01, 32'h0048_0000, 2);
		rd(8'h01, 3, d);
		chk(d[31:16], 16'h0048);
		chk({8'h00, d[15:8]}, 16'h008E);
	endtask : t_pec
	// Clock enable low: a finished conversion is not taken
	task automatic t_freeze();
		logic [31:0] d;
		ce        <= 1'b0;
		conv_raw  <= 16'h0100;
		conv_done <= 1'b1;
		i2c_master_model_i.tick(1);
		conv_done <= 1'b0;
		i2c_master_model_i.tick(4);
		ce <= 1'b1;
		i2c_master_model_i.tick(4);
		rd(8'h00, 2, d);
		chk(d[31:16], 16'h4B00);
	endtask : t_freeze
	// Clock held low in a read slot while the device drives a zero
	task automatic t_timeout(input logic dis);
		logic       a;
		logic [7:0] b;
		wr(8'h01, {8'h00, dis ? 8'h50 : 8'h40, 16'h0000}, 2);
		i2c_master_model_i.start_cond();
		i2c_master_model_i.byte_out({tsens_pkg::OWN_ADDR, 1'b0}, a);
		i2c_master_model_i.byte_out(8'h01, a);
		i2c_master_model_i.restart();
		i2c_master_model_i.byte_out({tsens_pkg::OWN_ADDR, 1'b1}, a);
		i2c_master_model_i.hold_low(20);
		chk({15'h0000, sda_oe}, 16'h0001);
		chk({15'h0000, sda_o}, 16'h0000);
		i2c_master_model_i.hold_low(TOUT + 40);
		chk({15'h0000, sda_oe}, {15'h0000, dis});
		i2c_master_model_i.byte_in(1'b1, b);
		chk({8'h00, b}, dis ? 16'h0000 : 16'h00FF);
		i2c_master_model_i.stop_cond();
	endtask : t_timeout
	// One-shot conversions over every resolution and both formats
	task automatic t_convert();
		logic [31:0] d;
		int          s0;
		logic [7:0]  lo  [6] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'hC1, 8'hE1};
		logic [15:0] raw [6] = '{16'h019D, 16'h019D, 16'h019D, 16'hFE63, 16'h019D, 16'h0960};
		logic [15:0] exp [6] = '{16'h1900, 16'h1980, 16'h19C0, 16'hE630, 16'h0CE0, 16'h4B00};
		for (int i = 0; i < 6; i++) begin
			s0 = starts;
			wr(8'h01, {8'h01, lo[i], 16'h0000}, 2);
			i2c_master_model_i.tick(8);
			chk(16'(starts), 16'(s0 + 1));
			chk({15'h0000, conv_shutdown}, 16'h0001);
			chk({14'h0000, conv_res}, {14'h0000, lo[i][6:5]});
			conv_raw  <= raw[i];
			conv_done <= 1'b1;
			i2c_master_model_i.tick(1);
			conv_done <= 1'b0;
			i2c_master_model_i.tick(2);
			rd(8'h00, 2, d);
			chk(d[31:16], exp[i]);
			rd(8'h01, 2, d);
			chk(d[31:16], {8'h01, lo[i] & 8'hFE});
		end
	endtask : t_convert
	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		close_out();
	end
	// Main sequence
	initial begin
		sys_rst   = 1'b1;
		ce        = 1'b1;
		conv_done = 1'b0;
		conv_raw  = 16'h0000;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (8) @(posedge clk);
		t_reset();
		t_foreign();
		t_limits();
		t_temp_ro();
		t_oneshot_idle();
		t_pec();
		t_timeout(1'b0);
		t_timeout(1'b1);
		t_convert();
		t_freeze();
		close_out();
	end
endmodule : test_tsens_regport
